// ---- hw/irq_prio_pkg.sv ----
package irq_prio_pkg;

    // bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 5;
    localparam int NUM_SRC = 17;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_EXT_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_INT_FLAGS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_VECTOR = 4'h8;

    // fields of external_irq_status_control
    localparam int BIT_MODE = 0;
    localparam int BIT_BLOCK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PENDING = 3;

    // fields of the vector register
    localparam int VEC_LSB = 0;
    localparam int PRIO_LSB = 16;
    localparam int VALID_BIT = 31;

    // priority numbers of sources
    localparam logic [PRIO_W-1:0] PRIO_SWI = 5'h00;
    localparam logic [PRIO_W-1:0] PRIO_EXT = 5'h01;
    localparam logic [PRIO_W-1:0] PRIO_PLL = 5'h02;
    localparam int PRIO_T1_CH0 = 3;
    localparam int PRIO_T2_CH0 = 6;
    localparam int PRIO_SP_RX = 9;
    localparam int PRIO_SP_TX = 10;
    localparam int PRIO_UART_ERR = 11;
    localparam int PRIO_UART_RX = 12;
    localparam int PRIO_UART_TX = 13;
    localparam int PRIO_KEYPAD = 14;
    localparam int PRIO_CONV = 15;
    localparam int PRIO_TIMEBASE = 16;

    // vector of priority 0; each lower rank sits two bytes below
    localparam logic [15:0] VECTOR_BASE = 16'hfffc;

    // values after reset
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_BLOCK = 1'b0;
    localparam logic RST_PIN = 1'b1;
    localparam logic RST_WAIT = 1'b1;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
    localparam logic [15:0] RST_VECTOR = 16'h0000;
    localparam logic [PRIO_W-1:0] RST_PRIO = 5'h00;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hw/src_gate.sv ----
`timescale 1ns/100ps
module src_gate #(
    parameter int N = 2
) (
    input wire logic [N-1:0] flags,
    input wire logic [N-1:0] enables,
    output logic req
);
    // any flag with its enable raises the shared request
    assign req = |(flags & enables);
endmodule // src_gate

// ---- hw/mcu_interrupt_prioritizer.sv ----
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - global mask bit blocks every source except software interrupt
// - fixed rank; priority zero is highest, larger numbers wait
// - external pin is priority 1, gated by its block bit
// - pll lock request is priority 2, gated by its enable
// - timer channel and wrap requests take priorities 3 through 8
// - serial peripheral receive and error flags share priority 9
// - serial peripheral transmit empty with enable raises priority 10
// - uart overrun, noise, framing, parity errors share one request
// - uart receive full and idle share one receive request
// - uart transmit empty and done share one transmit request
// - keypad 14, converter 15, timebase 16, each gated
// - read-only pending bit shows the external pin latch
// - writing one to ack clears the latch unless a set comes in the same cycle; ack reads zero
// - block bit one stops external requests; reset clears it
// - mode one: falling edge and low level; zero: edge only
module mcu_interrupt_prioritizer (
    input wire logic REF_CLK,
    input wire logic RST,
    // register bus
    input wire logic [irq_prio_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [irq_prio_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [irq_prio_pkg::DATA_W-1:0] AVS_READDATA,
    output logic [1:0] AVS_RESPONSE,
    output logic AVS_WAITREQUEST,
    // external pin, active low
    input wire logic EXT_IRQ_N,
    // cpu side
    input wire logic GLOBAL_IRQ_MASK,
    input wire logic SOFTWARE_INTERRUPT_INSTR,
    input wire logic VECTOR_TAKEN,
    output logic CPU_IRQ_REQ,
    output logic [15:0] CPU_VECTOR_ADDR,
    output logic [irq_prio_pkg::PRIO_W-1:0] CPU_VECTOR_PRIO,
    // clock generator
    input wire logic PLL_LOCK_FLAG,
    input wire logic PLL_LOCK_IRQ_EN,
    // first timer
    input wire logic FIRST_TIMER_CHAN0_FLAG,
    input wire logic FIRST_TIMER_CHAN0_IRQ_EN,
    input wire logic FIRST_TIMER_CHAN1_FLAG,
    input wire logic FIRST_TIMER_CHAN1_IRQ_EN,
    input wire logic FIRST_TIMER_WRAP_FLAG,
    input wire logic FIRST_TIMER_WRAP_IRQ_EN,
    // second timer
    input wire logic SECOND_TIMER_CHAN0_FLAG,
    input wire logic SECOND_TIMER_CHAN0_IRQ_EN,
    input wire logic SECOND_TIMER_CHAN1_FLAG,
    input wire logic SECOND_TIMER_CHAN1_IRQ_EN,
    input wire logic SECOND_TIMER_WRAP_FLAG,
    input wire logic SECOND_TIMER_WRAP_IRQ_EN,
    // serial peripheral
    input wire logic SP_RX_FULL_FLAG,
    input wire logic SP_RX_IRQ_EN,
    input wire logic SP_OVERFLOW_FLAG,
    input wire logic SP_MODE_FAULT_FLAG,
    input wire logic SP_ERROR_IRQ_EN,
    input wire logic SP_TX_EMPTY_FLAG,
    input wire logic SP_TX_IRQ_EN,
    // uart
    input wire logic UART_OVERRUN_FLAG,
    input wire logic UART_OVERRUN_IRQ_EN,
    input wire logic UART_NOISE_FLAG,
    input wire logic UART_NOISE_IRQ_EN,
    input wire logic UART_FRAME_ERR_FLAG,
    input wire logic UART_FRAME_ERR_IRQ_EN,
    input wire logic UART_PARITY_ERR_FLAG,
    input wire logic UART_PARITY_IRQ_EN,
    input wire logic UART_RX_FULL_FLAG,
    input wire logic UART_RX_IRQ_EN,
    input wire logic UART_IDLE_FLAG,
    input wire logic UART_IDLE_IRQ_EN,
    input wire logic UART_TX_EMPTY_FLAG,
    input wire logic UART_TX_EMPTY_IRQ_EN,
    input wire logic UART_TX_DONE_FLAG,
    input wire logic UART_TX_DONE_IRQ_EN,
    // keypad, converter, timebase
    input wire logic KEYPAD_FLAG,
    input wire logic KEYPAD_IRQ_BLOCK,
    input wire logic CONV_DONE_FLAG,
    input wire logic CONV_IRQ_EN,
    input wire logic TIMEBASE_FLAG,
    input wire logic TIMEBASE_IRQ_EN
);
    import irq_prio_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic pin_sync1;
        logic pin_sync2;
        logic pin_prev;
        logic latch;
        logic block;
        logic mode;
        logic wait_req;
        logic [DATA_W-1:0] rdata;
        logic [1:0] resp;
        logic irq_out;
        logic [15:0] vector;
        logic [PRIO_W-1:0] prio;
    } state_t;

    localparam state_t STATE_RESET = '{
        pin_sync1: RST_PIN,
        pin_sync2: RST_PIN,
        pin_prev: RST_PIN,
        latch: 1'b0,
        block: RST_BLOCK,
        mode: RST_MODE,
        wait_req: RST_WAIT,
        rdata: RST_RDATA,
        resp: RESP_OKAY,
        irq_out: 1'b0,
        vector: RST_VECTOR,
        prio: RST_PRIO
    };

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // grouped sources

    logic sp_rx_req;
    logic uart_err_req;
    logic uart_rx_req;
    logic uart_tx_req;
    logic pll_req;
    logic tmr1_ch0_req;
    logic tmr1_ch1_req;
    logic tmr1_wrap_req;
    logic tmr2_ch0_req;
    logic tmr2_ch1_req;
    logic tmr2_wrap_req;
    logic sp_tx_req;

    src_gate #(.N(3)) sp_rx_gate (
        .flags({SP_RX_FULL_FLAG, SP_OVERFLOW_FLAG, SP_MODE_FAULT_FLAG}),
        .enables({SP_RX_IRQ_EN, SP_ERROR_IRQ_EN, SP_ERROR_IRQ_EN}),
        .req(sp_rx_req)
    );

    src_gate #(.N(4)) uart_err_gate (
        .flags({UART_OVERRUN_FLAG, UART_NOISE_FLAG, UART_FRAME_ERR_FLAG,
                UART_PARITY_ERR_FLAG}),
        .enables({UART_OVERRUN_IRQ_EN, UART_NOISE_IRQ_EN, UART_FRAME_ERR_IRQ_EN,
                  UART_PARITY_IRQ_EN}),
        .req(uart_err_req)
    );

    src_gate #(.N(2)) uart_rx_gate (
        .flags({UART_RX_FULL_FLAG, UART_IDLE_FLAG}),
        .enables({UART_RX_IRQ_EN, UART_IDLE_IRQ_EN}),
        .req(uart_rx_req)
    );

    src_gate #(.N(2)) uart_tx_gate (
        .flags({UART_TX_EMPTY_FLAG, UART_TX_DONE_FLAG}),
        .enables({UART_TX_EMPTY_IRQ_EN, UART_TX_DONE_IRQ_EN}),
        .req(uart_tx_req)
    );

    // single flag and enable pairs
    src_gate #(.N(1)) pll_gate (
        .flags(PLL_LOCK_FLAG),
        .enables(PLL_LOCK_IRQ_EN),
        .req(pll_req)
    );
    src_gate #(.N(1)) tmr1_ch0_gate (
        .flags(FIRST_TIMER_CHAN0_FLAG),
        .enables(FIRST_TIMER_CHAN0_IRQ_EN),
        .req(tmr1_ch0_req)
    );
    src_gate #(.N(1)) tmr1_ch1_gate (
        .flags(FIRST_TIMER_CHAN1_FLAG),
        .enables(FIRST_TIMER_CHAN1_IRQ_EN),
        .req(tmr1_ch1_req)
    );
    src_gate #(.N(1)) tmr1_wrap_gate (
        .flags(FIRST_TIMER_WRAP_FLAG),
        .enables(FIRST_TIMER_WRAP_IRQ_EN),
        .req(tmr1_wrap_req)
    );
    src_gate #(.N(1)) tmr2_ch0_gate (
        .flags(SECOND_TIMER_CHAN0_FLAG),
        .enables(SECOND_TIMER_CHAN0_IRQ_EN),
        .req(tmr2_ch0_req)
    );
    src_gate #(.N(1)) tmr2_ch1_gate (
        .flags(SECOND_TIMER_CHAN1_FLAG),
        .enables(SECOND_TIMER_CHAN1_IRQ_EN),
        .req(tmr2_ch1_req)
    );
    src_gate #(.N(1)) tmr2_wrap_gate (
        .flags(SECOND_TIMER_WRAP_FLAG),
        .enables(SECOND_TIMER_WRAP_IRQ_EN),
        .req(tmr2_wrap_req)
    );
    src_gate #(.N(1)) sp_tx_gate (
        .flags(SP_TX_EMPTY_FLAG),
        .enables(SP_TX_IRQ_EN),
        .req(sp_tx_req)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // request vector, index equals priority number

    logic [NUM_SRC-1:0] int_flags;
    logic [NUM_SRC-1:0] unmasked;

    always_comb begin
        int_flags = '0;
        int_flags[PRIO_SWI] = SOFTWARE_INTERRUPT_INSTR;
        int_flags[PRIO_EXT] = state_reg.latch & ~state_reg.block;
        int_flags[PRIO_PLL] = pll_req;
        int_flags[PRIO_T1_CH0] = tmr1_ch0_req;
        int_flags[PRIO_T1_CH0 + 1] = tmr1_ch1_req;
        int_flags[PRIO_T1_CH0 + 2] = tmr1_wrap_req;
        int_flags[PRIO_T2_CH0] = tmr2_ch0_req;
        int_flags[PRIO_T2_CH0 + 1] = tmr2_ch1_req;
        int_flags[PRIO_T2_CH0 + 2] = tmr2_wrap_req;
        int_flags[PRIO_SP_RX] = sp_rx_req;
        int_flags[PRIO_SP_TX] = sp_tx_req;
        int_flags[PRIO_UART_ERR] = uart_err_req;
        int_flags[PRIO_UART_RX] = uart_rx_req;
        int_flags[PRIO_UART_TX] = uart_tx_req;
        int_flags[PRIO_KEYPAD] = KEYPAD_FLAG & ~KEYPAD_IRQ_BLOCK;
        int_flags[PRIO_CONV] = CONV_DONE_FLAG & CONV_IRQ_EN;
        int_flags[PRIO_TIMEBASE] = TIMEBASE_FLAG & TIMEBASE_IRQ_EN;
    end

    // global mask spares only the software interrupt
    always_comb begin
        unmasked = int_flags & {{(NUM_SRC-1){~GLOBAL_IRQ_MASK}}, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // priority pick

    logic any_req;
    logic [PRIO_W-1:0] win_prio;

    always_comb begin
        any_req = |unmasked;
        win_prio = '0;
        // scan from the bottom so the smallest number is kept last
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (unmasked[i]) begin
                win_prio = PRIO_W'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic bus_req;
    logic bus_commit;
    logic hit_ctrl;
    logic hit_flags;
    logic hit_vector;
    logic mapped;
    logic ack_write;
    logic [DATA_W-1:0] read_mux;

    always_comb begin
        bus_req = AVS_READ | AVS_WRITE;
        bus_commit = AVS_WRITE & ~state_reg.wait_req;
        hit_ctrl = AVS_ADDRESS == OFS_EXT_CTRL;
        hit_flags = AVS_ADDRESS == OFS_INT_FLAGS;
        hit_vector = AVS_ADDRESS == OFS_VECTOR;
        mapped = hit_ctrl | hit_flags | hit_vector;
        ack_write = bus_commit & hit_ctrl & AVS_BYTEENABLE[0] & AVS_WRITEDATA[BIT_ACK];
        read_mux = '0;
        if (hit_ctrl) begin
            read_mux[BIT_MODE] = state_reg.mode;
            read_mux[BIT_BLOCK] = state_reg.block;
            read_mux[BIT_ACK] = 1'b0;
            read_mux[BIT_PENDING] = state_reg.latch;
        end else if (hit_flags) begin
            read_mux[NUM_SRC-1:0] = int_flags;
        end else if (hit_vector) begin
            read_mux[VEC_LSB +: 16] = state_reg.vector;
            read_mux[PRIO_LSB +: PRIO_W] = state_reg.prio;
            read_mux[VALID_BIT] = state_reg.irq_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external pin

    logic pin_fall;
    logic pin_low;
    logic latch_set;
    logic latch_clr;

    always_comb begin
        pin_fall = state_reg.pin_prev & ~state_reg.pin_sync2;
        pin_low = ~state_reg.pin_sync2;
        latch_set = pin_fall | (state_reg.mode & pin_low);
        latch_clr = ack_write | (VECTOR_TAKEN & state_reg.irq_out
                                 & (state_reg.prio == PRIO_EXT));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        state_next.pin_sync1 = EXT_IRQ_N;
        state_next.pin_sync2 = state_reg.pin_sync1;
        state_next.pin_prev = state_reg.pin_sync2;
        // a set in the clearing cycle survives
        if (latch_set) begin
            state_next.latch = 1'b1;
        end else if (latch_clr) begin
            state_next.latch = 1'b0;
        end
        if (bus_commit & hit_ctrl & AVS_BYTEENABLE[0]) begin
            state_next.block = AVS_WRITEDATA[BIT_BLOCK];
            state_next.mode = AVS_WRITEDATA[BIT_MODE];
        end
        // one wait cycle, then a single ready cycle
        state_next.wait_req = ~(bus_req & state_reg.wait_req);
        if (bus_req & state_reg.wait_req) begin
            state_next.rdata = AVS_READ ? read_mux : '0;
            state_next.resp = mapped ? RESP_OKAY : RESP_SLVERR;
        end
        state_next.irq_out = any_req;
        if (any_req) begin
            state_next.prio = win_prio;
            state_next.vector = 16'(VECTOR_BASE - 16'({win_prio, 1'b0}));
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign AVS_READDATA = state_reg.rdata;
    assign AVS_RESPONSE = state_reg.resp;
    assign AVS_WAITREQUEST = state_reg.wait_req;
    assign CPU_IRQ_REQ = state_reg.irq_out;
    assign CPU_VECTOR_ADDR = state_reg.vector;
    assign CPU_VECTOR_PRIO = state_reg.prio;

endmodule // mcu_interrupt_prioritizer

// ---- test/mcu_interrupt_prioritizer_chk.sv ----
`timescale 1ns/100ps
module mcu_interrupt_prioritizer_chk (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [irq_prio_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic [irq_prio_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic [1:0] AVS_RESPONSE,
    input wire logic AVS_WAITREQUEST,
    input wire logic GLOBAL_IRQ_MASK,
    input wire logic SOFTWARE_INTERRUPT_INSTR,
    input wire logic CPU_IRQ_REQ,
    input wire logic [15:0] CPU_VECTOR_ADDR,
    input wire logic [irq_prio_pkg::PRIO_W-1:0] CPU_VECTOR_PRIO,
    input wire logic PLL_LOCK_FLAG,
    input wire logic PLL_LOCK_IRQ_EN,
    input wire logic KEYPAD_FLAG,
    input wire logic KEYPAD_IRQ_BLOCK
);
    import irq_prio_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////
    wait_one_a: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    ack_reads_zero_a: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == OFS_EXT_CTRL
        |=> !AVS_WAITREQUEST && !AVS_READDATA[BIT_ACK]) else $error("ack bit read as one");
    unmapped_err_a: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 4'hc
        |=> AVS_RESPONSE == RESP_SLVERR && AVS_READDATA == '0) else $error("unmapped read");
    swi_wins_a: assert property (SOFTWARE_INTERRUPT_INSTR |=> CPU_IRQ_REQ &&
        CPU_VECTOR_PRIO == PRIO_SWI && CPU_VECTOR_ADDR == VECTOR_BASE) else $error("swi lost");
    mask_blocks_a: assert property (GLOBAL_IRQ_MASK && !SOFTWARE_INTERRUPT_INSTR
        |=> !CPU_IRQ_REQ) else $error("request while masked");
    vec_map_a: assert property (CPU_IRQ_REQ |->
        CPU_VECTOR_ADDR == VECTOR_BASE - {10'h0, CPU_VECTOR_PRIO, 1'h0}) else $error("bad vector");
    pll_rank_a: assert property (PLL_LOCK_FLAG && PLL_LOCK_IRQ_EN && !GLOBAL_IRQ_MASK
        |=> CPU_IRQ_REQ && CPU_VECTOR_PRIO <= PRIO_PLL) else $error("pll request lost");
    keypad_gate_a: assert property (CPU_IRQ_REQ && CPU_VECTOR_PRIO == PRIO_KEYPAD
        |-> $past(KEYPAD_FLAG && !KEYPAD_IRQ_BLOCK)) else $error("keypad not gated");
endmodule // mcu_interrupt_prioritizer_chk
bind mcu_interrupt_prioritizer mcu_interrupt_prioritizer_chk mcu_interrupt_prioritizer_chk_i (.*);

// ---- test/cpu_fetch_model.sv ----
`timescale 1ns/100ps
module cpu_fetch_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    input wire logic en,
    output logic taken
);
    logic hold_reg;
    // one fetch pulse per request, then two cycles of rest
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            taken <= 1'h0;
            hold_reg <= 1'h0;
        end else begin
            taken <= en & irq & !taken & !hold_reg;
            hold_reg <= taken;
        end
    end
endmodule // cpu_fetch_model

// ---- test/test_mcu_interrupt_prioritizer.sv ----
`timescale 1ns/100ps
module test_mcu_interrupt_prioritizer;
    import irq_prio_pkg::*;
    logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, pin_n = 1'h1;
    logic gmask = 1'h0, sw_int = 1'h0, cpu_en = 1'h0, wait_req, taken, irq;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q, rq;
    logic [1:0] resp;
    logic [15:0] vec;
    logic [4:0] prio;
    logic [42:0] s = 43'h0;
    int n_errors = 0, total_checks = 0;
    int fi[21] = '{0,2,4,6,8,10,12,14,16,17,19,21,23,25,27,29,31,33,35,39,41};
    int ei[21] = '{1,3,5,7,9,11,13,15,18,18,20,22,24,26,28,30,32,34,36,40,42};
    int pr[21] = '{2,3,4,5,6,7,8,9,9,9,10,11,11,11,11,12,12,13,13,15,16};
    always #4 clk = ~clk;
    mcu_interrupt_prioritizer mcu_interrupt_prioritizer_i (.REF_CLK(clk), .RST(rst),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_RESPONSE(resp),
        .AVS_WAITREQUEST(wait_req), .EXT_IRQ_N(pin_n), .GLOBAL_IRQ_MASK(gmask),
        .SOFTWARE_INTERRUPT_INSTR(sw_int), .VECTOR_TAKEN(taken), .CPU_IRQ_REQ(irq),
        .CPU_VECTOR_ADDR(vec), .CPU_VECTOR_PRIO(prio), .PLL_LOCK_FLAG(s[0]),
        .PLL_LOCK_IRQ_EN(s[1]), .FIRST_TIMER_CHAN0_FLAG(s[2]), .FIRST_TIMER_CHAN0_IRQ_EN(s[3]),
        .FIRST_TIMER_CHAN1_FLAG(s[4]), .FIRST_TIMER_CHAN1_IRQ_EN(s[5]),
        .FIRST_TIMER_WRAP_FLAG(s[6]), .FIRST_TIMER_WRAP_IRQ_EN(s[7]),
        .SECOND_TIMER_CHAN0_FLAG(s[8]), .SECOND_TIMER_CHAN0_IRQ_EN(s[9]),
        .SECOND_TIMER_CHAN1_FLAG(s[10]), .SECOND_TIMER_CHAN1_IRQ_EN(s[11]),
        .SECOND_TIMER_WRAP_FLAG(s[12]), .SECOND_TIMER_WRAP_IRQ_EN(s[13]),
        .SP_RX_FULL_FLAG(s[14]), .SP_RX_IRQ_EN(s[15]), .SP_OVERFLOW_FLAG(s[16]),
        .SP_MODE_FAULT_FLAG(s[17]), .SP_ERROR_IRQ_EN(s[18]), .SP_TX_EMPTY_FLAG(s[19]),
        .SP_TX_IRQ_EN(s[20]), .UART_OVERRUN_FLAG(s[21]), .UART_OVERRUN_IRQ_EN(s[22]),
        .UART_NOISE_FLAG(s[23]), .UART_NOISE_IRQ_EN(s[24]), .UART_FRAME_ERR_FLAG(s[25]),
        .UART_FRAME_ERR_IRQ_EN(s[26]), .UART_PARITY_ERR_FLAG(s[27]), .UART_PARITY_IRQ_EN(s[28]),
        .UART_RX_FULL_FLAG(s[29]), .UART_RX_IRQ_EN(s[30]), .UART_IDLE_FLAG(s[31]),
        .UART_IDLE_IRQ_EN(s[32]), .UART_TX_EMPTY_FLAG(s[33]), .UART_TX_EMPTY_IRQ_EN(s[34]),
        .UART_TX_DONE_FLAG(s[35]), .UART_TX_DONE_IRQ_EN(s[36]), .KEYPAD_FLAG(s[37]),
        .KEYPAD_IRQ_BLOCK(s[38]), .CONV_DONE_FLAG(s[39]), .CONV_IRQ_EN(s[40]),
        .TIMEBASE_FLAG(s[41]), .TIMEBASE_IRQ_EN(s[42]));
    cpu_fetch_model cpu_fetch_model_i (.clk(clk), .rst(rst), .irq(irq), .en(cpu_en),
        .taken(taken));
    ////////////////////////////////////////////////////////////////
    task complete_run;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'h0 && k < 20);
        q = rdata;
        rq = {30'h0, resp};
        rd <= 1'h0;
        wr <= 1'h0;
        @(posedge clk);
        if (k >= 20) begin
            n_errors++;
            complete_run;
        end
    endtask
    task rreg(input logic [3:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        cmp(q, e);
    endtask
    ////////////////////////////////////////////////////////////////
    task reset_and_refusal;
        rreg(OFS_EXT_CTRL, 32'h0);
        cmp(rq, {30'h0, RESP_OKAY});
        bus(1'h1, 4'hc, 32'h3);
        cmp(rq, {30'h0, RESP_SLVERR});
        rreg(OFS_EXT_CTRL, 32'h0);
        rreg(4'hc, 32'h0);
        cmp(rq, {30'h0, RESP_SLVERR});
    endtask
    task source_gating;
        for (int i = 0; i < 21; i++) begin
            s <= 43'h1 << fi[i];
            repeat (2) @(posedge clk);
            rreg(OFS_INT_FLAGS, 32'h0);
            s <= (43'h1 << fi[i]) | (43'h1 << ei[i]);
            repeat (2) @(posedge clk);
            rreg(OFS_INT_FLAGS, 32'h1 << pr[i]);
            rreg(OFS_VECTOR, {1'h1, 10'h0, 5'(pr[i]), 16'hfffc - 16'(2 * pr[i])});
        end
        s <= 43'h3 << 37;
        repeat (2) @(posedge clk);
        rreg(OFS_INT_FLAGS, 32'h0);
        s <= 43'h1 << 37;
        repeat (2) @(posedge clk);
        rreg(OFS_INT_FLAGS, 32'h1 << 14);
    endtask
    task global_mask;
        s <= 43'hc;
        gmask <= 1'h1;
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        sw_int <= 1'h1;
        repeat (2) @(posedge clk);
        cmp({irq, prio, vec}, {1'h1, 5'h0, 16'hfffc});
        sw_int <= 1'h0;
        gmask <= 1'h0;
        repeat (2) @(posedge clk);
        cmp({irq, prio, vec}, {1'h1, 5'h3, 16'hfff6});
    endtask
    task rank_and_pin;
        s <= '1;
        repeat (2) @(posedge clk);
        cmp({irq, prio, vec}, {1'h1, 5'h2, 16'hfff8});
        pin_n <= 1'h0;
        repeat (5) @(posedge clk);
        cmp({irq, prio, vec}, {1'h1, 5'h1, 16'hfffa});
        rreg(OFS_EXT_CTRL, 32'h8);
        bus(1'h1, OFS_EXT_CTRL, 32'h4);
        rreg(OFS_EXT_CTRL, 32'h0);
        bus(1'h1, OFS_EXT_CTRL, 32'h1);
        bus(1'h1, OFS_EXT_CTRL, 32'h5);
        rreg(OFS_EXT_CTRL, 32'h9);
        bus(1'h1, OFS_EXT_CTRL, 32'h3);
        s <= 43'h0;
        repeat (2) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        rreg(OFS_EXT_CTRL, 32'hb);
        pin_n <= 1'h1;
        repeat (3) @(posedge clk);
        bus(1'h1, OFS_EXT_CTRL, 32'h4);
        rreg(OFS_EXT_CTRL, 32'h0);
    endtask
    task vector_fetch;
        pin_n <= 1'h0;
        repeat (5) @(posedge clk);
        cmp({irq, prio, vec}, {1'h1, 5'h1, 16'hfffa});
        cpu_en <= 1'h1;
        repeat (6) @(posedge clk);
        cpu_en <= 1'h0;
        rreg(OFS_EXT_CTRL, 32'h0);
        pin_n <= 1'h1;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        reset_and_refusal;
        source_gating;
        global_mask;
        rank_and_pin;
        vector_fetch;
        complete_run;
    end
endmodule // test_mcu_interrupt_prioritizer
